// ---- verilog/led_seq_consts.svh ----
`ifndef LED_SEQ_CONSTS_SVH
`define LED_SEQ_CONSTS_SVH

// clock and time base
`define CLK_NS 8
`define US_NS 1000

// times in microseconds
`define T_PWM_US 3333
`define T_ON_UNIT_US 106600
`define T_OFF_UNIT_US 320000
`define T_INIT_US 1700000
`define T_PLAY_US 2000000
`define T_IDLE_US 200
`define T_PROG_US 50
`define T_ARM_US 200

// ramp table
`define STEP_FIRST 5'h00
`define STEP_LAST 5'h1f
`define STEP_FULL 5'h08

// register offsets
`define A_RAMP1 3'h0
`define A_FIRST_BLINK_PULSE 3'h1
`define A_RAMP2 3'h2
`define A_SECOND_BLINK_PULSE 3'h3
`define A_CONTROL 3'h4
`define A_STATUS 3'h5

// reset values and field layout
`define R_RAMP1 8'h55
`define R_FIRST_BLINK_PULSE 8'h55
`define R_RAMP2 8'h55
`define R_SECOND_BLINK_PULSE 8'h00
`define R_CONTROL 8'h00
`define CTL_WMASK 8'hc7
`define CTL_FOLLOW 0
`define CTL_PLAY 1
`define CTL_SLOW 2
`define CTL_RANGE_HI 7
`define CTL_RANGE_LO 6

`endif

// ---- verilog/led_seq_pkg.sv ----
package led_seq_pkg;

    typedef enum logic [5:0] {
        ST_IDLE = 6'h01,
        ST_INIT = 6'h02,
        ST_PROG = 6'h04,
        ST_FOLLOW = 6'h08,
        ST_ARM = 6'h10,
        ST_PAT = 6'h20
    } run_state_t;

    typedef enum logic [3:0] {
        PH_RISE = 4'h1,
        PH_ON = 4'h2,
        PH_FALL = 4'h4,
        PH_OFF = 4'h8
    } phase_t;

    typedef struct packed {
        run_state_t state;
        phase_t phase;
        logic on_second;
        logic oneshot;
        logic sync1;
        logic sync2;
        logic ctrl_d;
        logic [15:0] us_div;
        logic [11:0] pwm_us;
        logic [3:0] rep;
        logic [4:0] step;
        logic [23:0] phase_us;
        logic [21:0] high_us;
        logic [21:0] low_us;
        logic [7:0] first_ramp_rate_reg;
        logic [7:0] first_blink_pulse;
        logic [7:0] second_ramp_rate_reg;
        logic [7:0] second_blink_pulse;
        logic [7:0] control_reg;
        logic [7:0] rdata;
        logic led;
        logic full;
    } seq_state_t;

endpackage

// ---- verilog/led_blink_pattern_sequencer.sv ----
// Chosen here: the address map and the plain strobed port.
`timescale 1ns/10ps
`include "led_seq_consts.svh"

module led_blink_pattern_sequencer #(
    parameter int unsigned US_CYCLES = (`US_NS + `CLK_NS - 1) / `CLK_NS,
    parameter int unsigned PWM_US = `T_PWM_US,
    parameter int unsigned ON_UNIT_US = `T_ON_UNIT_US,
    parameter int unsigned OFF_UNIT_US = `T_OFF_UNIT_US,
    parameter int unsigned INIT_US = `T_INIT_US,
    parameter int unsigned PLAY_US = `T_PLAY_US,
    parameter int unsigned IDLE_US = `T_IDLE_US,
    parameter int unsigned PROG_US = `T_PROG_US,
    parameter int unsigned ARM_US = `T_ARM_US
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // register port
    input wire logic [2:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [7:0] rdata,
    // control pin
    input wire logic ctrl_in,
    // led driver
    output logic led_drive_output,
    output logic led_full_scale,
    output logic [1:0] current_range_bits
);
    import led_seq_pkg::*;

    localparam logic [15:0] US_LAST = 16'(US_CYCLES - 1);
    localparam logic [11:0] PWM_LAST = 12'(PWM_US - 1);
    localparam logic [23:0] ON_UNIT = 24'(ON_UNIT_US);
    localparam logic [23:0] OFF_UNIT = 24'(OFF_UNIT_US);
    localparam logic [21:0] L_INIT = 22'(INIT_US);
    localparam logic [21:0] L_PLAY = 22'(PLAY_US);
    localparam logic [21:0] L_IDLE = 22'(IDLE_US);
    localparam logic [21:0] L_PROG = 22'(PROG_US);
    localparam logic [21:0] L_ARM = 22'(ARM_US);
    localparam logic [21:0] L_SAT = 22'h3fffff;

    localparam seq_state_t RST_VAL = '{
        state: ST_IDLE,
        phase: PH_RISE,
        on_second: 1'b0,
        oneshot: 1'b0,
        sync1: 1'b0,
        sync2: 1'b0,
        ctrl_d: 1'b0,
        us_div: 16'h0000,
        pwm_us: 12'h000,
        rep: 4'h0,
        step: `STEP_FIRST,
        phase_us: 24'h000000,
        high_us: 22'h000000,
        low_us: 22'h000000,
        first_ramp_rate_reg: `R_RAMP1,
        first_blink_pulse: `R_FIRST_BLINK_PULSE,
        second_ramp_rate_reg: `R_RAMP2,
        second_blink_pulse: `R_SECOND_BLINK_PULSE,
        control_reg: `R_CONTROL,
        rdata: 8'h00,
        led: 1'b0,
        full: 1'b0
    };

    // on-time of one pwm period per brightness step, in microseconds
    function automatic logic [11:0] step_on(input logic [4:0] s);
        logic [11:0] r;
        r = 12'h000;
        case (s)
            5'h00: r = 12'h000;
            5'h01: r = 12'h00d;
            5'h02: r = 12'h041;
            5'h03: r = 12'h09c;
            5'h04: r = 12'h12b;
            5'h05: r = 12'h1e2;
            5'h06: r = 12'h2cc;
            5'h07: r = 12'h3f8;
            5'h08: r = 12'h0a9;
            5'h09: r = 12'h0dd;
            5'h0a: r = 12'h111;
            5'h0b: r = 12'h153;
            5'h0c: r = 12'h1a1;
            5'h0d: r = 12'h1ef;
            5'h0e: r = 12'h24a;
            5'h0f: r = 12'h2a5;
            5'h10: r = 12'h30d;
            5'h11: r = 12'h375;
            5'h12: r = 12'h3eb;
            5'h13: r = 12'h46d;
            5'h14: r = 12'h4fc;
            5'h15: r = 12'h58b;
            5'h16: r = 12'h61b;
            5'h17: r = 12'h6c4;
            5'h18: r = 12'h76d;
            5'h19: r = 12'h816;
            5'h1a: r = 12'h8da;
            5'h1b: r = 12'h99d;
            5'h1c: r = 12'ha6d;
            5'h1d: r = 12'hb3e;
            5'h1e: r = 12'hc1b;
            default: r = 12'hd05;
        endcase
        return r;
    endfunction

    // hold length in microseconds; fits 24 bits for 15 counts, slow, 320 ms unit
    function automatic logic [23:0] hold_limit(input logic [3:0] cnt, input logic slow,
                                               input logic [23:0] unit);
        logic [23:0] m;
        m = unit * {20'h00000, cnt};
        return slow ? {m[22:0], 1'b0} : m;
    endfunction

    function automatic seq_state_t start_pulse(input seq_state_t s, input logic second);
        seq_state_t t;
        t = s;
        t.state = ST_PAT;
        t.phase = PH_RISE;
        t.on_second = second;
        t.step = `STEP_FIRST;
        t.rep = 4'h0;
        t.pwm_us = 12'h000;
        t.phase_us = 24'h000000;
        return t;
    endfunction

    seq_state_t s_r;
    seq_state_t s_nxt;
    logic tick;
    logic wrap;
    logic ctrl;
    logic rise_e;
    logic fall_e;
    logic [1:0] mode;
    logic [7:0] ramp_sel;
    logic [7:0] pulse_sel;
    logic [3:0] up_n;
    logic [3:0] dn_n;
    logic [23:0] on_lim;
    logic [23:0] off_lim;
    logic second_on;
    logic led_n;
    logic full_n;

    always_comb begin
        s_nxt = s_r;
        // pin passes two flops before any logic reads it
        s_nxt.sync1 = ctrl_in;
        s_nxt.sync2 = s_r.sync1;
        s_nxt.ctrl_d = s_r.sync2;
        ctrl = s_r.sync2;
        rise_e = ctrl & ~s_r.ctrl_d;
        fall_e = ~ctrl & s_r.ctrl_d;
        mode = {s_r.control_reg[`CTL_PLAY], s_r.control_reg[`CTL_FOLLOW]};
        ramp_sel = s_r.on_second ? s_r.second_ramp_rate_reg : s_r.first_ramp_rate_reg;
        pulse_sel = s_r.on_second ? s_r.second_blink_pulse : s_r.first_blink_pulse;
        up_n = ramp_sel[7:4];
        dn_n = ramp_sel[3:0];
        on_lim = hold_limit(pulse_sel[7:4], s_r.control_reg[`CTL_SLOW], ON_UNIT);
        off_lim = hold_limit(pulse_sel[3:0], s_r.control_reg[`CTL_SLOW], OFF_UNIT);
        second_on = (s_r.second_blink_pulse != 8'h00);

        // one microsecond enable; all timing counts this tick
        tick = (s_r.us_div == US_LAST);
        wrap = tick && (s_r.pwm_us == PWM_LAST);
        s_nxt.us_div = tick ? 16'h0000 : s_r.us_div + 16'h0001;
        if (tick) begin
            s_nxt.pwm_us = wrap ? 12'h000 : s_r.pwm_us + 12'h001;
            s_nxt.phase_us = s_r.phase_us + 24'h000001;
        end
        if (ctrl) begin
            s_nxt.low_us = 22'h000000;
            if (tick && s_r.high_us != L_SAT) begin
                s_nxt.high_us = s_r.high_us + 22'h000001;
            end
        end else begin
            s_nxt.high_us = 22'h000000;
            if (tick && s_r.low_us != L_SAT) begin
                s_nxt.low_us = s_r.low_us + 22'h000001;
            end
        end

        // register writes; reserved control bits stay zero
        if (wr) begin
            case (addr)
                `A_RAMP1: s_nxt.first_ramp_rate_reg = wdata;
                `A_FIRST_BLINK_PULSE: s_nxt.first_blink_pulse = wdata;
                `A_RAMP2: s_nxt.second_ramp_rate_reg = wdata;
                `A_SECOND_BLINK_PULSE: s_nxt.second_blink_pulse = wdata;
                `A_CONTROL: s_nxt.control_reg = wdata & `CTL_WMASK;
                default: ;
            endcase
        end
        s_nxt.rdata = 8'h00;
        if (rd) begin
            case (addr)
                `A_RAMP1: s_nxt.rdata = s_r.first_ramp_rate_reg;
                `A_FIRST_BLINK_PULSE: s_nxt.rdata = s_r.first_blink_pulse;
                `A_RAMP2: s_nxt.rdata = s_r.second_ramp_rate_reg;
                `A_SECOND_BLINK_PULSE: s_nxt.rdata = s_r.second_blink_pulse;
                `A_CONTROL: s_nxt.rdata = s_r.control_reg;
                `A_STATUS: s_nxt.rdata = {s_r.led, s_r.on_second, s_r.state};
                default: s_nxt.rdata = 8'h00;
            endcase
        end

        case (s_r.state)
            ST_IDLE: begin
                s_nxt.pwm_us = 12'h000;
                s_nxt.phase_us = 24'h000000;
                s_nxt.step = `STEP_FIRST;
                s_nxt.rep = 4'h0;
                s_nxt.oneshot = 1'b0;
                s_nxt.on_second = 1'b0;
                if (rise_e) begin
                    case (mode)
                        2'b00: s_nxt.state = ST_INIT;
                        2'b01: s_nxt.state = ST_FOLLOW;
                        2'b10: s_nxt = start_pulse(s_nxt, 1'b0);
                        default: s_nxt.state = ST_ARM;
                    endcase
                end
            end
            ST_INIT: begin
                if (ctrl && s_r.high_us >= L_PLAY) begin
                    s_nxt = start_pulse(s_nxt, 1'b0);
                end else if (fall_e && s_r.high_us < L_PROG) begin
                    s_nxt.state = ST_PROG;
                end else if (!ctrl && s_r.low_us >= L_IDLE) begin
                    s_nxt.state = ST_IDLE;
                end
            end
            ST_PROG: begin
                // serial programming is handled elsewhere; here the LED is only held off
                if (!ctrl && s_r.low_us >= L_IDLE) begin
                    s_nxt.state = ST_IDLE;
                end
            end
            ST_FOLLOW: begin
                if (!ctrl && s_r.low_us >= L_IDLE) begin
                    s_nxt.state = ST_IDLE;
                end
            end
            ST_ARM: begin
                if (!ctrl) begin
                    s_nxt.state = ST_IDLE;
                end else if (s_r.high_us >= L_ARM) begin
                    s_nxt = start_pulse(s_nxt, 1'b0);
                    s_nxt.oneshot = 1'b1;
                end
            end
            ST_PAT: begin
                case (s_r.phase)
                    PH_RISE: begin
                        if (up_n == 4'h0) begin
                            s_nxt.phase = PH_ON;
                            s_nxt.step = `STEP_LAST;
                            s_nxt.phase_us = 24'h000000;
                        end else if (wrap) begin
                            if (s_r.rep == up_n - 4'h1) begin
                                s_nxt.rep = 4'h0;
                                s_nxt.step = s_r.step + 5'h01;
                                // 31 steps reach full; the last level is the on hold itself
                                if (s_r.step == `STEP_LAST - 5'h01) begin
                                    s_nxt.phase = PH_ON;
                                    s_nxt.phase_us = 24'h000000;
                                end
                            end else begin
                                s_nxt.rep = s_r.rep + 4'h1;
                            end
                        end
                    end
                    PH_ON: begin
                        if (s_r.phase_us >= on_lim) begin
                            s_nxt.phase = PH_FALL;
                            s_nxt.rep = 4'h0;
                            s_nxt.pwm_us = 12'h000;
                        end
                    end
                    PH_FALL: begin
                        if (dn_n == 4'h0) begin
                            s_nxt.phase = PH_OFF;
                            s_nxt.step = `STEP_FIRST;
                            s_nxt.phase_us = 24'h000000;
                        end else if (wrap) begin
                            if (s_r.rep == dn_n - 4'h1) begin
                                s_nxt.rep = 4'h0;
                                s_nxt.step = s_r.step - 5'h01;
                                if (s_r.step == `STEP_FIRST + 5'h01) begin
                                    s_nxt.phase = PH_OFF;
                                    s_nxt.phase_us = 24'h000000;
                                end
                            end else begin
                                s_nxt.rep = s_r.rep + 4'h1;
                            end
                        end
                    end
                    default: begin
                        if (s_r.phase_us >= off_lim) begin
                            if (s_r.oneshot) begin
                                // input is looked at only once the pulse has fully ended
                                if (ctrl) begin
                                    s_nxt = start_pulse(s_nxt, 1'b0);
                                end else begin
                                    s_nxt.state = ST_IDLE;
                                end
                            end else if (!s_r.on_second && second_on) begin
                                s_nxt = start_pulse(s_nxt, 1'b1);
                            end else begin
                                s_nxt = start_pulse(s_nxt, 1'b0);
                            end
                        end
                    end
                endcase
                if (!s_r.oneshot && !ctrl && s_r.low_us >= L_IDLE) begin
                    s_nxt.state = ST_IDLE;
                end
            end
            default: s_nxt.state = ST_IDLE;
        endcase

        led_n = 1'b0;
        full_n = 1'b0;
        case (s_r.state)
            ST_INIT: begin
                led_n = ctrl && (s_r.high_us < L_INIT);
                full_n = 1'b1;
            end
            ST_FOLLOW: begin
                led_n = ctrl;
                full_n = 1'b1;
            end
            ST_PAT: begin
                case (s_r.phase)
                    PH_RISE, PH_FALL: begin
                        led_n = (s_r.pwm_us < step_on(s_r.step));
                        full_n = (s_r.step >= `STEP_FULL);
                    end
                    PH_ON: begin
                        led_n = 1'b1;
                        full_n = 1'b1;
                    end
                    default: begin
                        led_n = 1'b0;
                        full_n = 1'b0;
                    end
                endcase
                // outside one-shot, low input blanks the LED at once, the idle return waits out glitches
                if (!s_r.oneshot && !ctrl) begin
                    led_n = 1'b0;
                end
            end
            default: begin
                led_n = 1'b0;
                full_n = 1'b0;
            end
        endcase
        s_nxt.led = led_n;
        s_nxt.full = full_n;
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s_r <= RST_VAL;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign rdata = s_r.rdata;
    assign led_drive_output = s_r.led;
    assign led_full_scale = s_r.full;
    assign current_range_bits = s_r.control_reg[`CTL_RANGE_HI:`CTL_RANGE_LO];

endmodule

// ---- dv/led_seq_properties.sv ----
`timescale 1ns/10ps
module led_seq_properties (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // register port
    input wire logic [2:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr,
    input wire logic rd,
    input wire logic [7:0] rdata,
    // control pin and led driver
    input wire logic ctrl_in,
    input wire logic led_drive_output,
    input wire logic led_full_scale,
    input wire logic [1:0] current_range_bits
);
    logic [1:0] mode_r;
    logic [3:0] low_cnt_r;
    logic [3:0] high_cnt_r;
    logic seen_high_r;

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    // mode mirrored from control writes: only valid while modes change at idle
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            mode_r <= 2'h0;
            low_cnt_r <= 4'h0;
            high_cnt_r <= 4'h0;
            seen_high_r <= 1'b0;
        end else begin
            if (wr && addr == 3'h4) begin
                mode_r <= wdata[1:0];
            end
            low_cnt_r <= ctrl_in ? 4'h0 : ((low_cnt_r == 4'hf) ? 4'hf : low_cnt_r + 4'h1);
            high_cnt_r <= !ctrl_in ? 4'h0 : ((high_cnt_r == 4'hf) ? 4'hf : high_cnt_r + 4'h1);
            seen_high_r <= seen_high_r | ctrl_in;
        end
    end

    AST_RESET_DARK: assert property ($fell(rst) |-> !led_drive_output && !led_full_scale)
        else $error("led active right after reset");
    AST_IDLE_QUIET: assert property (!seen_high_r |-> !led_drive_output)
        else $error("led lit before any control pin activity");
    AST_RDATA_IDLE: assert property (!$past(rd) |-> rdata == 8'h00)
        else $error("read data not zero outside read answer cycle");
    AST_CTRL_MASK: assert property (rd && addr == 3'h4 |=> rdata[5:3] == 3'h0)
        else $error("control spare bits read nonzero");
    AST_UNMAPPED: assert property (rd && addr[2:1] == 2'b11 |=> rdata == 8'h00)
        else $error("unmapped read nonzero");
    AST_RANGE_WRITE: assert property (wr && addr == 3'h4 && wdata[7:6] == 2'h3 |->
        ##[1:2] current_range_bits == 2'h3)
        else $error("range bits not taken from control write");
    AST_LOW_OFF: assert property (low_cnt_r == 4'hf && mode_r != 2'h3 |-> !led_drive_output)
        else $error("led on while control pin held low");
    AST_FOLLOW_HOLD: assert property (mode_r == 2'h1 && high_cnt_r == 4'hf |-> led_drive_output)
        else $error("follow mode led off while pin high");
    AST_FOLLOW_RISE: assert property (mode_r == 2'h1 && $rose(ctrl_in) |->
        ##[2:6] led_drive_output)
        else $error("follow mode led late after pin rise");

    cover property (mode_r == 2'h2 && $rose(led_drive_output));
    cover property (mode_r == 2'h3 && $rose(led_drive_output));
    cover property ($rose(led_full_scale));
endmodule

bind led_blink_pattern_sequencer led_seq_properties u_props (
    .clk(clk),
    .rst(rst),
    .addr(addr),
    .wdata(wdata),
    .wr(wr),
    .rd(rd),
    .rdata(rdata),
    .ctrl_in(ctrl_in),
    .led_drive_output(led_drive_output),
    .led_full_scale(led_full_scale),
    .current_range_bits(current_range_bits)
);

// ---- dv/led_ctrl_host.sv ----
`timescale 1ns/10ps
module led_ctrl_host #(
    parameter int unsigned US_CYCLES = 2
) (
    // clock
    input wire logic clk,
    // control pin
    output logic ctrl_in
);
    initial ctrl_in = 1'b0;

    // level changes land just after an edge, then hold for the given microseconds
    task automatic drive(input logic v, input int us);
        @(posedge clk);
        ctrl_in <= v;
        repeat (us * US_CYCLES) @(posedge clk);
    endtask
endmodule

// ---- dv/led_blink_pattern_sequencer_tb.sv ----
`timescale 1ns/10ps
module led_blink_pattern_sequencer_tb;
    localparam int USC = 2;
    localparam int PWM = 20;
    localparam int ON_U = 50;
    localparam int OFF_U = 100;
    localparam int INIT_T = 300;
    localparam int PLAY_T = 400;
    localparam int IDLE_T = 20;
    localparam int PROG_T = 5;
    localparam int ARM_T = 20;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [2:0] addr = 3'h0;
    logic [7:0] wdata = 8'h00;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [7:0] rdata;
    logic ctrl_in;
    logic led_drive_output;
    logic led_full_scale;
    logic [1:0] current_range_bits;
    int n_fail = 0;
    int n_compared = 0;

    always #4 clk = ~clk;

    led_blink_pattern_sequencer #(.US_CYCLES(USC), .PWM_US(PWM), .ON_UNIT_US(ON_U),
        .OFF_UNIT_US(OFF_U), .INIT_US(INIT_T), .PLAY_US(PLAY_T), .IDLE_US(IDLE_T),
        .PROG_US(PROG_T), .ARM_US(ARM_T)) u_dut (.clk(clk), .rst(rst), .addr(addr),
        .wdata(wdata), .wr(wr),
        .rd(rd), .rdata(rdata), .ctrl_in(ctrl_in), .led_drive_output(led_drive_output),
        .led_full_scale(led_full_scale), .current_range_bits(current_range_bits));
    led_ctrl_host #(.US_CYCLES(USC)) u_host (.clk(clk), .ctrl_in(ctrl_in));

    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
            n_fail++;
        end
    endtask

    task automatic chk_near(input string name, input int exp, input int got, input int tol);
        n_compared++;
        if (got < exp - tol || got > exp + tol) begin
            $display("CHECK FAILED %s expected %0d seen %0d", name, exp, got);
            n_fail++;
        end
    endtask

    task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask

    // read data stand only in the cycle after the strobe edge
    task automatic rd_reg(input logic [2:0] a, output logic [7:0] d);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        d = rdata;
    endtask

    task automatic wait_led(input logic v, input int limit, output int n);
        n = 0;
        #1;
        while (led_drive_output !== v && n < limit) begin
            @(posedge clk);
            #1;
            n++;
        end
    endtask

    task automatic count_led(input logic v, output int n);
        n = 0;
        while (led_drive_output === v && n < 20000) begin
            @(posedge clk);
            #1;
            n++;
        end
    endtask

    // alternating high and low spans, starting with the high one already showing
    task automatic expect_pattern(input int exp[6], input int cnt);
        int got;
        for (int i = 0; i < cnt; i++) begin
            count_led(~i[0], got);
            chk_near("led span", exp[i], got, 4);
        end
    endtask

    task automatic go_idle();
        u_host.drive(1'b0, 40);
    endtask

    task automatic t_regs();
        logic [7:0] d;
        logic [7:0] exp [5] = '{8'h55, 8'h55, 8'h55, 8'h00, 8'h00};
        for (int i = 0; i < 5; i++) begin
            rd_reg(i[2:0], d);
            chk("reset value", exp[i], d);
        end
        wr_reg(3'h6, 8'haa);
        rd_reg(3'h6, d);
        chk("unmapped", 8'h00, d);
        wr_reg(3'h5, 8'hff);
        rd_reg(3'h5, d);
        chk("idle state", 8'h01, {2'b00, d[5:0]});
        chk("led idle", 1'b0, led_drive_output);
    endtask

    task automatic t_range();
        logic [7:0] d;
        wr_reg(3'h4, 8'hfc);
        rd_reg(3'h4, d);
        chk("control mask", 8'hc4, d);
        chk("range 11", 2'h3, current_range_bits);
        wr_reg(3'h4, 8'h40);
        @(posedge clk);
        #1;
        chk("range 01", 2'h1, current_range_bits);
    endtask

    task automatic t_follow();
        wr_reg(3'h4, 8'h01);
        u_host.drive(1'b1, 30);
        chk("follow high", 1'b1, led_drive_output);
        u_host.drive(1'b0, 5);
        chk("follow low", 1'b0, led_drive_output);
        go_idle();
    endtask

    task automatic t_default();
        logic [7:0] d;
        int n;
        wr_reg(3'h4, 8'h00);
        wr_reg(3'h0, 8'h00);
        wr_reg(3'h1, 8'h21);
        u_host.drive(1'b1, 100);
        chk("tracks pin", 1'b1, led_drive_output);
        u_host.drive(1'b0, 5);
        chk("initial pulse only", 1'b0, led_drive_output);
        go_idle();
        rd_reg(3'h5, d);
        chk("back to idle", 8'h01, {2'b00, d[5:0]});
        u_host.drive(1'b1, 2);
        u_host.drive(1'b0, 3);
        rd_reg(3'h5, d);
        chk("program entry", 8'h04, {2'b00, d[5:0]});
        chk("program dark", 1'b0, led_drive_output);
        go_idle();
        u_host.drive(1'b1, 350);
        chk("gap dark", 1'b0, led_drive_output);
        wait_led(1'b1, 300, n);
        chk_near("play start", 104, n, 10);
        expect_pattern('{200, 200, 200, 0, 0, 0}, 3);
        go_idle();
    endtask

    task automatic t_play();
        int n;
        wr_reg(3'h4, 8'h02);
        u_host.drive(1'b1, 0);
        wait_led(1'b1, 20, n);
        expect_pattern('{200, 200, 200, 200, 0, 0}, 4);
        go_idle();
        wr_reg(3'h2, 8'h00);
        wr_reg(3'h3, 8'h11);
        u_host.drive(1'b1, 0);
        wait_led(1'b1, 20, n);
        expect_pattern('{200, 200, 100, 200, 200, 0}, 5);
        // lower the pin while the LED is lit, so the blanking is really seen
        wait_led(1'b1, 400, n);
        chk("lit before stop", 1'b1, led_drive_output);
        u_host.drive(1'b0, 5);
        chk("stop on low", 1'b0, led_drive_output);
        go_idle();
        wr_reg(3'h3, 8'h00);
        wr_reg(3'h4, 8'h06);
        u_host.drive(1'b1, 0);
        wait_led(1'b1, 20, n);
        expect_pattern('{400, 400, 400, 0, 0, 0}, 3);
        go_idle();
    endtask

    task automatic t_ramp();
        int n;
        int m;
        wr_reg(3'h0, 8'h10);
        wr_reg(3'h4, 8'h02);
        u_host.drive(1'b1, 0);
        n = 0;
        while (led_full_scale !== 1'b1 && n < 2000) begin
            @(posedge clk);
            #1;
            n++;
        end
        chk_near("low current steps", 8 * PWM * USC, n, 8);
        count_led(1'b1, m);
        // n also holds the pin-to-sequencer delay of about 4 cycles
        chk_near("rise then on", 31 * PWM * USC + 2 * ON_U * USC + 4 - n, m, 8);
        go_idle();
    endtask

    task automatic t_oneshot();
        int n;
        wr_reg(3'h0, 8'h00);
        wr_reg(3'h4, 8'h03);
        u_host.drive(1'b1, 0);
        wait_led(1'b1, 200, n);
        chk_near("arm delay", 44, n, 6);
        u_host.drive(1'b0, 0);
        expect_pattern('{199, 200, 0, 0, 0, 0}, 1);
        wait_led(1'b1, 300, n);
        chk("no replay when low", 1'b0, led_drive_output);
        u_host.drive(1'b1, 0);
        wait_led(1'b1, 200, n);
        expect_pattern('{200, 200, 200, 0, 0, 0}, 3);
        go_idle();
    endtask

    initial begin
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        t_regs();
        t_range();
        t_follow();
        t_default();
        t_play();
        t_ramp();
        t_oneshot();
        wrap_up();
    end

    // whole run is about 8000 cycles
    initial begin
        repeat (80000) @(posedge clk);
        n_fail++;
        wrap_up();
    end
endmodule
